// ===== sbp_core.sv
// Subchannel bit processor: per-frame FIFO bit insertion into channel bytes and extraction back.
// Assumes a FIFO store that answers byte requests and a channel switch taking one byte per channel per frame.
// Notes on behaviour
// - FIFO may carry fewer than eight bits
// - Start bit zero to seven, lowest bit
// - Unclaimed transmit bits come from fill mask
// - Fill mask never touches received data
// - Select register picks channel for mask write
// - Mask belongs to channel of indexing FIFO
// - Reset configuration leaves every FIFO disabled
// - Transparent: one byte per FIFO per frame
// - Transparent receive stores whole byte
// - Fixed mapping: FIFO number equals channel
// - Free mapping merges several FIFO fields
// - Free transparent receive copies byte everywhere
// - HDLC sends next bits in next frame
// - HDLC fetches byte when fewer bits left than field width
// - HDLC receive appends field bits to stream
// - Free HDLC gives independent streams
// - Count zero means eight bits
// - Mask matters only below eight bits
// - Framing bit: zero HDLC, one transparent
// - Free enable zero forces fixed mapping
module sbp_core
  import sbp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic TX_REQ,
  output logic [sbp_pkg::IDX_W-1:0] TX_FIFO,
  input wire logic TX_ACK,
  input wire logic [7:0] TX_DATA,
  output logic CH_TX_VALID,
  output logic [sbp_pkg::IDX_W-1:0] CH_TX_NUM,
  output logic [7:0] CH_TX_DATA,
  input wire logic [sbp_pkg::N_CH*8-1:0] CH_RX_DATA,
  output logic RX_PUSH,
  output logic [sbp_pkg::IDX_W-1:0] RX_FIFO,
  output logic [7:0] RX_DATA,
  output logic FRAME_TICK
);
  import sbp_pkg::*;

  typedef struct packed {
    sbp_state_e st;
    logic [11:0] tick;
    logic [15:0] frame;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] sel_num;
    logic sel_dir;
    logic free_en;
    logic overrun;
    logic [2*N_FIFO-1:0][CFG_W-1:0] cfg;
    logic [N_FIFO-1:0][15:0] tbuf;
    logic [N_FIFO-1:0][4:0] tcnt;
    logic [N_FIFO-1:0][15:0] racc;
    logic [N_FIFO-1:0][3:0] rcnt;
    logic [N_CH-1:0][7:0] snap;
    logic [7:0] cur;
    logic ack;
    logic [31:0] rdat;
    logic txv;
    logic [IDX_W-1:0] txn;
    logic [7:0] txd;
    logic rxp;
    logic [IDX_W-1:0] rxf;
    logic [7:0] rxd;
    logic ftick;
  } sbp_core_s;

  sbp_core_s q;
  sbp_core_s d;

  function automatic logic [IDX_W-1:0] chan_of(input logic [CFG_W-1:0] c, input logic [IDX_W-1:0] num,
                                                input logic free);
    return free ? c[CFG_CH_LSB +: IDX_W] : num;
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic rx_phase;
  logic [IDX_W:0] fsel;
  logic [CFG_W-1:0] fcfg;
  logic [IDX_W-1:0] fch;
  logic [7:0] mem_rd;
  logic [7:0] f_merged;
  logic [7:0] f_ext;
  logic [3:0] f_width;
  logic [7:0] f_src;
  logic tx_need;
  logic bus_req;
  logic sw_mask_we;
  logic eng_we;
  logic mem_we;
  logic [IDX_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [IDX_W-1:0] mem_ra;
  logic [IDX_W:0] sel_idx;
  logic [IDX_W-1:0] mask_ch;
  logic last_idx;

  assign rx_phase = (q.st == ST_RX);
  assign fsel = {rx_phase, q.idx};
  assign fcfg = q.cfg[fsel];
  assign fch = chan_of(fcfg, q.idx, q.free_en);
  assign f_src = fcfg[CFG_TRP_BIT] ? q.cur : q.tbuf[q.idx][7:0];
  assign last_idx = (q.idx == IDX_W'(N_FIFO - 1));
  assign sel_idx = {q.sel_dir, q.sel_num};
  assign mask_ch = chan_of(q.cfg[{1'b0, q.sel_num}], q.sel_num, q.free_en);

  sbp_field u_field (
    .cnt(fcfg[CFG_CNT_LSB +: 3]),
    .start(fcfg[CFG_START_LSB +: 3]),
    .src(f_src),
    .positional(fcfg[CFG_TRP_BIT]),
    .old(mem_rd),
    .chan(q.snap[fch]),
    .merged(f_merged),
    .extracted(f_ext),
    .width(f_width)
  );

  assign tx_need = fcfg[CFG_EN_BIT] && (fcfg[CFG_TRP_BIT] || (q.tcnt[q.idx] < {1'b0, f_width}));
  assign bus_req = WB_CYC_I && WB_STB_I && !q.ack;
  assign eng_we = (q.st == ST_TWR);
  assign sw_mask_we = bus_req && WB_WE_I && (WB_ADR_I == OFS_MASK) && WB_SEL_I[0] && !eng_we;
  assign mem_we = eng_we || sw_mask_we;
  assign mem_wa = eng_we ? fch : mask_ch;
  assign mem_wd = eng_we ? f_merged : WB_DAT_I[7:0];
  assign mem_ra = (q.st == ST_ORD) ? q.idx : fch;

  sbp_mask_mem #(
    .DEPTH(N_CH),
    .AW(IDX_W)
  ) u_mask (
    .clk(CORE_CLK),
    .we(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(mem_ra),
    .rd_data(mem_rd)
  );

  always_comb begin
    logic [15:0] acc;
    logic [4:0] cnt;
    logic [31:0] wv;
    acc = 16'h0000;
    cnt = 5'h00;
    wv = 32'h0000_0000;
    d = q;
    d.txv = 1'b0;
    d.rxp = 1'b0;
    d.ftick = 1'b0;
    d.ack = 1'b0;

    // Frame timebase: one pulse every 125 us
    if (q.tick == 12'(FRAME_CYC - 1)) begin
      d.tick = 12'h000;
      d.ftick = 1'b1;
    end else begin
      d.tick = q.tick + 12'h001;
    end

    // Register bus
    if (bus_req && !(WB_WE_I && WB_ADR_I == OFS_MASK && eng_we)) begin
      d.ack = 1'b1;
      d.rdat = 32'h0000_0000;
      case (WB_ADR_I)
        OFS_SEL: begin
          wv = lane_merge({27'h0, q.sel_dir, 2'b00, q.sel_num}, WB_DAT_I, WB_SEL_I);
          d.rdat = {27'h0, q.sel_dir, 2'b00, q.sel_num};
          if (WB_WE_I) begin
            d.sel_num = wv[SEL_NUM_LSB +: IDX_W];
            d.sel_dir = wv[SEL_DIR_BIT];
          end
        end
        OFS_CFG: begin
          wv = lane_merge({22'h0, q.cfg[sel_idx]}, WB_DAT_I, WB_SEL_I);
          d.rdat = {22'h0, q.cfg[sel_idx]};
          if (WB_WE_I) begin
            d.cfg[sel_idx] = wv[CFG_W-1:0];
          end
        end
        OFS_MODE: begin
          wv = lane_merge({31'h0, q.free_en}, WB_DAT_I, WB_SEL_I);
          d.rdat = {31'h0, q.free_en};
          if (WB_WE_I) begin
            d.free_en = wv[MODE_FREE_BIT];
          end
        end
        OFS_STAT: begin
          d.rdat = 32'h0000_0000;
          d.rdat[15:0] = q.frame;
          d.rdat[STAT_BUSY_BIT] = (q.st != ST_IDLE);
          d.rdat[STAT_OVR_BIT] = q.overrun;
          if (WB_WE_I && WB_SEL_I[2] && WB_DAT_I[STAT_OVR_BIT]) begin
            d.overrun = 1'b0;
          end
        end
        default: begin
          d.rdat = 32'h0000_0000;
        end
      endcase
    end

    // Frame engine
    case (q.st)
      ST_IDLE: begin
        if (q.ftick) begin
          d.snap = CH_RX_DATA;
          d.idx = '0;
          d.frame = q.frame + 16'h0001;
          d.st = ST_TFETCH;
        end
      end
      ST_TFETCH: begin
        if (!fcfg[CFG_EN_BIT]) begin
          d.idx = q.idx + IDX_W'(1);
          d.st = last_idx ? ST_ORD : ST_TFETCH;
        end else if (!tx_need) begin
          d.st = ST_TRD;
        end else if (TX_ACK) begin
          if (fcfg[CFG_TRP_BIT]) begin
            d.cur = TX_DATA;
          end else begin
            d.tbuf[q.idx] = q.tbuf[q.idx] | 16'({8'h00, TX_DATA} << q.tcnt[q.idx]);
            d.tcnt[q.idx] = q.tcnt[q.idx] + 5'h08;
          end
          d.st = ST_TRD;
        end
      end
      ST_TRD: begin
        d.st = ST_TWR;
      end
      ST_TWR: begin
        // Inserted bits stay in the mask store for later frames
        if (!fcfg[CFG_TRP_BIT]) begin
          d.tbuf[q.idx] = q.tbuf[q.idx] >> f_width;
          d.tcnt[q.idx] = q.tcnt[q.idx] - {1'b0, f_width};
        end
        d.idx = q.idx + IDX_W'(1);
        d.st = last_idx ? ST_ORD : ST_TFETCH;
      end
      ST_ORD: begin
        d.st = ST_OEMIT;
      end
      ST_OEMIT: begin
        d.txv = 1'b1;
        d.txn = q.idx;
        d.txd = mem_rd;
        d.idx = q.idx + IDX_W'(1);
        d.st = (q.idx == IDX_W'(N_CH - 1)) ? ST_RX : ST_ORD;
      end
      ST_RX: begin
        if (fcfg[CFG_EN_BIT]) begin
          if (fcfg[CFG_TRP_BIT]) begin
            d.rxp = 1'b1;
            d.rxf = q.idx;
            d.rxd = q.snap[fch];
          end else begin
            acc = q.racc[q.idx] | 16'({8'h00, f_ext} << q.rcnt[q.idx]);
            cnt = {1'b0, q.rcnt[q.idx]} + {1'b0, f_width};
            if (cnt >= 5'h08) begin
              d.rxp = 1'b1;
              d.rxf = q.idx;
              d.rxd = acc[7:0];
              acc = acc >> 8;
              cnt = cnt - 5'h08;
            end
            d.racc[q.idx] = acc;
            d.rcnt[q.idx] = cnt[3:0];
          end
        end
        d.idx = q.idx + IDX_W'(1);
        if (last_idx) begin
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // A frame that starts while the engine is still busy is dropped; set wins over clear
    if (q.ftick && q.st != ST_IDLE) begin
      d.overrun = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.free_en <= MODE_RST;
      q.cfg <= {2*N_FIFO{CFG_RST}};
    end else begin
      q <= d;
    end
  end

  assign WB_ACK_O = q.ack;
  assign WB_DAT_O = q.rdat;
  assign TX_REQ = (q.st == ST_TFETCH) && tx_need;
  assign TX_FIFO = q.idx;
  assign CH_TX_VALID = q.txv;
  assign CH_TX_NUM = q.txn;
  assign CH_TX_DATA = q.txd;
  assign RX_PUSH = q.rxp;
  assign RX_FIFO = q.rxf;
  assign RX_DATA = q.rxd;
  assign FRAME_TICK = q.ftick;
endmodule

// ===== sbp_pkg.sv
// Constants, register map and state codes of the subchannel bit processor.
// Assumes one 25 MHz core clock and a 32-bit classic Wishbone register bus.
package sbp_pkg;
  localparam int N_FIFO = 4;
  localparam int N_CH = 4;
  localparam int IDX_W = 2;
  localparam int CFG_W = 10;

  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;

  localparam int SEL_NUM_LSB = 0;
  localparam int SEL_DIR_BIT = 4;
  localparam int CFG_CNT_LSB = 0;
  localparam int CFG_START_LSB = 3;
  localparam int CFG_TRP_BIT = 6;
  localparam int CFG_EN_BIT = 7;
  localparam int CFG_CH_LSB = 8;
  localparam int MODE_FREE_BIT = 0;
  localparam int STAT_BUSY_BIT = 16;
  localparam int STAT_OVR_BIT = 17;

  localparam logic [CFG_W-1:0] CFG_RST = 10'h000;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic MODE_RST = 1'b0;

  localparam int CLK_NS = 40;
  localparam int FRAME_NS = 125000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_TFETCH = 7'b0000010,
    ST_TRD = 7'b0000100,
    ST_TWR = 7'b0001000,
    ST_ORD = 7'b0010000,
    ST_OEMIT = 7'b0100000,
    ST_RX = 7'b1000000
  } sbp_state_e;
endpackage

// ===== sbp_field.sv
// Bit field placement for one FIFO: claimed mask, merge into a channel byte, extraction.
// Assumes purely combinational use by the frame engine.
module sbp_field (
  input wire logic [2:0] cnt,
  input wire logic [2:0] start,
  input wire logic [7:0] src,
  input wire logic positional,
  input wire logic [7:0] old,
  input wire logic [7:0] chan,
  output logic [7:0] merged,
  output logic [7:0] extracted,
  output logic [3:0] width
);
  logic [3:0] n;
  logic [3:0] room;
  logic [7:0] lowm;
  logic [7:0] m;
  logic [7:0] aligned;

  always_comb begin
    n = (cnt == 3'h0) ? 4'h8 : {1'b0, cnt};
    room = 4'h8 - {1'b0, start};
    width = (n > room) ? room : n;
    lowm = 8'((16'h0001 << width) - 16'h0001);
    m = 8'({8'h00, lowm} << start);
    aligned = positional ? src : 8'({8'h00, src} << start);
    merged = (old & ~m) | (aligned & m);
    extracted = 8'({8'h00, chan & m} >> start);
  end
endmodule

// ===== sbp_mask_mem.sv
// One fill-mask byte per transmit channel, single write port, registered read.
// Assumes the owner arbitrates between writers.
module sbp_mask_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== sbp_core_monitor.sv
// Checker of bus, frame and channel timing, watching the top ports only.
// Assumes the sbp_core port names and the package frame length.
module sbp_core_monitor
  import sbp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic TX_REQ,
  input wire logic TX_ACK,
  input wire logic [IDX_W-1:0] TX_FIFO,
  input wire logic CH_TX_VALID,
  input wire logic [IDX_W-1:0] CH_TX_NUM,
  input wire logic [7:0] CH_TX_DATA,
  input wire logic FRAME_TICK
);
  logic [11:0] gap_q;
  logic seen_q;
  // Cycles since the last frame tick
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      gap_q <= 12'h000;
      seen_q <= 1'b0;
    end else if (FRAME_TICK) begin
      gap_q <= 12'h001;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 12'h001;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  ack_time_a: assert property ($rose(WB_STB_I) && WB_CYC_I |-> ##[1:2] WB_ACK_O)
    else $error("no ack within two cycles");
  rdata_hold_a: assert property ($changed(WB_DAT_O) |-> WB_ACK_O) else $error("read data moved without ack");
  frame_period_a: assert property (FRAME_TICK && seen_q |-> gap_q == FRAME_CYC)
    else $error("frame period wrong");
  frame_bound_a: assert property (seen_q |-> gap_q <= FRAME_CYC) else $error("frame tick missing");
  tx_hold_a: assert property (TX_REQ && !TX_ACK |=> TX_REQ && $stable(TX_FIFO))
    else $error("byte request dropped or moved");
  emit_gap_a: assert property (CH_TX_VALID |=> !CH_TX_VALID) else $error("channel bytes too close");
  ch_order_a: assert property (CH_TX_VALID && CH_TX_NUM != 2'd3 |->
    ##2 CH_TX_VALID && CH_TX_NUM == $past(CH_TX_NUM, 2) + 2'd1) else $error("channel order wrong");
  emit_hold_a: assert property ($changed(CH_TX_DATA) |-> CH_TX_VALID) else $error("channel byte moved");
endmodule
bind sbp_core sbp_core_monitor i_sbp_core_monitor (.*);

// ===== sbp_fifo_model.sv
// Far-side FIFO store: answers byte requests, at once or after a stall.
// Assumes the request is held until acknowledged.
module sbp_fifo_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  output logic ack,
  output logic [7:0] data
);
  logic [7:0] n_q;
  logic [1:0] wt_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
      data <= 8'h00;
      n_q <= 8'h00;
      wt_q <= 2'h0;
    end else if (req && !ack) begin
      // Every other byte stalls for two cycles
      if (wt_q == {n_q[0], 1'b0}) begin
        ack <= 1'b1;
        data <= 8'h3c + 8'h25 * n_q;
        wt_q <= 2'h0;
      end else begin
        wt_q <= wt_q + 2'h1;
        data <= ~data;
      end
    end else begin
      // Idle data lines never keep the old byte
      ack <= 1'b0;
      data <= ~data;
      n_q <= n_q + {7'h00, ack};
    end
  end
endmodule

// ===== sbp_core_tb_top.sv
// Testbench: registers set over Wishbone, then channel and FIFO bytes judged frame by frame.
// Assumes sbp_core, the FIFO store model and the bound monitor.
module sbp_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sbp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rxd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dato;
  logic ack, treq, tack, chv, push, tick;
  logic [1:0] tf, chn, rxf;
  logic [7:0] td, chd, rxv;
  logic [7:0] lastb [4];
  logic [7:0] cho [4];
  logic [9:0] rxq [$];
  logic txb [$];
  int err_count = 0;
  int checks_done = 0;
  int cyc_n = 0;
  int hs = 0;
  sbp_core i_sbp_core (.CORE_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .TX_REQ(treq),
    .TX_FIFO(tf), .TX_ACK(tack), .TX_DATA(td), .CH_TX_VALID(chv), .CH_TX_NUM(chn), .CH_TX_DATA(chd),
    .CH_RX_DATA(rxd), .RX_PUSH(push), .RX_FIFO(rxf), .RX_DATA(rxv), .FRAME_TICK(tick));
  sbp_fifo_model i_sbp_fifo_model (.clk(clk), .rst_n(rst_n), .req(treq), .ack(tack), .data(td));
  initial begin
    forever #20 clk = ~clk;
  end
  task results;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 45000) begin
      err_count++;
      results;
    end
  end
  // Capture of channel bytes, receive pushes and FIFO handshake bytes, mid-cycle where they are settled
  always @(negedge clk) begin
    if (chv) cho[chn] = chd;
    if (push) rxq.push_back({rxf, rxv});
    if (treq && tack) begin
      hs++;
      lastb[tf] = td;
      if (tf == 2'd3) for (int i = 0; i < 8; i++) txb.push_back(td[i]);
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Request stands until the edge that samples ack high; data taken there
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic logic [9:0] cv(input logic [1:0] ch, input logic t, input logic [2:0] st, input logic [2:0] n);
    return {ch, 1'b1, t, st, n};
  endfunction
  task cfg(input logic [4:0] s, input logic [9:0] c);
    wb(OFS_SEL, 1'b1, {27'h0, s});
    wb(OFS_CFG, 1'b1, {22'h0, c});
  endtask
  task mask(input logic [1:0] s, input logic [7:0] m);
    wb(OFS_SEL, 1'b1, {30'h0, s});
    wb(OFS_MASK, 1'b1, {24'h0, m});
  endtask
  function automatic logic [8:0] rxg(input logic [1:0] f);
    foreach (rxq[i]) if (rxq[i][9:8] == f) return {1'b1, rxq[i][7:0]};
    return 9'h000;
  endfunction
  task frame;
    rxq.delete();
    hs = 0;
    do begin
      @(posedge clk);
    end while (tick !== 1'b1);
    do begin
      @(posedge clk);
    end while (!(chv === 1'b1 && chn === 2'd3));
    repeat (8) @(posedge clk);
  endtask
  task t_reset;
    wb(OFS_CFG, 1'b0, 32'h0);
    chk(rdat, {22'h0, CFG_RST});
    wb(OFS_MODE, 1'b0, 32'h0);
    chk(rdat, {31'h0, MODE_RST});
    wb(8'h40, 1'b1, 32'hffff_ffff);
    wb(8'h40, 1'b0, 32'h0);
    chk(rdat, 32'h0);
    for (int c = 0; c < 4; c++) mask(c[1:0], 8'h90 + 8'(c));
    cfg(5'h00, cv(2'd0, 1'b1, 3'd0, 3'd0));
    cfg(5'h10, cv(2'd0, 1'b1, 3'd0, 3'd0));
    rxd <= 32'h7e5a_c381;
    frame;
    chk(cho[0], lastb[0]);
    chk(cho[1], 8'h91);
    chk(rxg(2'd0), 9'h181);
    wb(OFS_STAT, 1'b0, 32'h0);
    chk(rdat, 32'h0000_0001);
  endtask
  task t_fixed;
    cfg(5'h00, cv(2'd0, 1'b1, 3'd2, 3'd3));
    cfg(5'h01, cv(2'd1, 1'b1, 3'd7, 3'd1));
    cfg(5'h10, cv(2'd0, 1'b1, 3'd2, 3'd3));
    mask(2'd0, 8'ha5);
    mask(2'd1, 8'h3c);
    rxd <= 32'h6b2d_e417;
    frame;
    chk(cho[0], (8'ha5 & 8'he3) | (lastb[0] & 8'h1c));
    chk(cho[1], (8'h3c & 8'h7f) | (lastb[1] & 8'h80));
    chk(hs, 2);
    chk(rxg(2'd0), 9'h117);
  endtask
  task t_free;
    wb(OFS_MODE, 1'b1, 32'h1);
    cfg(5'h00, cv(2'd2, 1'b1, 3'd0, 3'd2));
    cfg(5'h01, cv(2'd2, 1'b1, 3'd6, 3'd1));
    cfg(5'h02, cv(2'd2, 1'b1, 3'd2, 3'd3));
    cfg(5'h11, cv(2'd2, 1'b1, 3'd0, 3'd0));
    cfg(5'h12, cv(2'd2, 1'b1, 3'd0, 3'd0));
    mask(2'd0, 8'hb3);
    rxd <= 32'h11c9_2233;
    frame;
    chk(cho[2], (8'hb3 & 8'ha0) | (lastb[0] & 8'h03) | (lastb[1] & 8'h40) | (lastb[2] & 8'h1c));
    chk(rxg(2'd1), 9'h1c9);
    chk(rxg(2'd2), 9'h1c9);
  endtask
  task t_hdlc;
    logic rb [$];
    logic [7:0] e;
    wb(OFS_MODE, 1'b1, 32'h0);
    cfg(5'h03, cv(2'd3, 1'b0, 3'd2, 3'd3));
    cfg(5'h13, cv(2'd3, 1'b0, 3'd2, 3'd3));
    mask(2'd3, 8'h42);
    txb.delete();
    for (int f = 0; f < 7; f++) begin
      rxd[31:24] <= 8'(8'h2d + 37 * f);
      frame;
      for (int i = 0; i < 3; i++) rb.push_back(rxd[26 + i]);
      e = 8'h42 & 8'he3;
      for (int i = 0; i < 3; i++) e[2 + i] = txb.pop_front();
      chk(cho[3], e);
      chk(txb.size() < 8, 1);
      if (rb.size() >= 8) begin
        for (int i = 0; i < 8; i++) e[i] = rb.pop_front();
        chk(rxg(2'd3), {1'b1, e});
      end else chk(rxg(2'd3), 9'h000);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_fixed;
    t_free;
    t_hdlc;
    results;
  end
endmodule
